// file: wtc_pkg.sv
`default_nettype none
package wtc_pkg;
    // Byte size of the data store and of the uncached top page.
    localparam int unsigned CACHE_BYTES    = 8192;
    localparam int unsigned IO_PAGE_BYTES  = 8192;
    localparam int unsigned ADDR_W         = 22;
    localparam int unsigned DATA_W         = 16;
    // Word-addressed index and tag split.
    localparam int unsigned INDEX_W        = 12;
    localparam int unsigned TAG_W          = ADDR_W - INDEX_W - 1;
    localparam int unsigned ENTRIES        = CACHE_BYTES / 2;
    localparam logic [ADDR_W-1:0] IO_PAGE_BASE = 22'h3F_E000;
    localparam logic        VALID_RST      = 1'b0;

    typedef enum logic [4:0] {
        WTC_IDLE  = 5'b00001,
        WTC_MEM   = 5'b00010,
        WTC_INV   = 5'b00100,
        WTC_FLUSH = 5'b01000,
        WTC_DONE  = 5'b10000
    } wtc_state_e;
endpackage : wtc_pkg
`default_nettype wire

// file: wtc_cache.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Holds 8 Kbytes direct-mapped, write-through, with separate processor and DMA tag stores.
// - Only main memory on the private memory interconnect is cached; peripheral-bus memory never.
// - A processor read hit returns the stored word with no memory access and no change.
// - A normal processor read miss fetches from memory, returns the word and fills the entry.
// - A processor write hit updates both the entry and memory.
// - The top 8 Kbytes (the I/O page) are never cached and reads always reach the target.
// - Every DMA transaction is watched and a DMA write hit invalidates the entry.
// - DMA lookups run beside processor accesses; the processor stalls only for a DMA write hit or a flush.
// - A DMA tag parity error on a DMA write counts as a hit and invalidates the entry.
// - A processor tag or data parity error on a normal read counts as a miss.
// - A processor tag parity error on a normal byte write counts as a hit; bad parity is stored.
// - A tag or data parity error on a bypass read or write counts as a hit and invalidates.
// - Parity is ignored on force-miss cycles and on normal word writes.
// - A bypass hit invalidates and goes to memory; a bypass miss goes to memory only.
module wtc_cache #(
    parameter int unsigned ADDR_W  = wtc_pkg::ADDR_W,
    parameter int unsigned DATA_W  = wtc_pkg::DATA_W,
    parameter int unsigned INDEX_W = wtc_pkg::INDEX_W
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Processor side.
    input  wire logic              cpuReq,
    input  wire logic              cpuWrite,
    input  wire logic              cpuByte,
    input  wire logic              cpuBypass,
    input  wire logic              cpuForceMiss,
    input  wire logic              ioPageSelect,
    input  wire logic              periphMem,
    input  wire logic [ADDR_W-1:0] cpuAddr,
    input  wire logic [DATA_W-1:0] cpuWdata,
    output logic                   cpuReady,
    output logic [DATA_W-1:0]      cpuRdata,
    output logic                   cpuStall,
    // Flush all valid bits.
    input  wire logic              flushReq,
    input  wire logic              wrongTagParity,
    // Main memory on the private memory interconnect.
    output logic                   memReq,
    output logic                   memWrite,
    output logic                   memByte,
    output logic [ADDR_W-1:0]      memAddr,
    output logic [DATA_W-1:0]      memWdata,
    input  wire logic              memAck,
    input  wire logic [DATA_W-1:0] memRdata,
    // DMA snoop port.
    input  wire logic              dmaValid,
    input  wire logic              dmaWrite,
    input  wire logic [ADDR_W-1:0] dmaAddr,
    output logic                   dmaInvalidate
);
    localparam int unsigned TAG_W   = ADDR_W - INDEX_W - 1;
    localparam int unsigned ENTRIES = 1 << INDEX_W;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [INDEX_W-1:0] idxOf(input logic [ADDR_W-1:0] a);
        return a[INDEX_W:1];
    endfunction : idxOf

    function automatic logic [TAG_W-1:0] tagOf(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:INDEX_W+1];
    endfunction : tagOf

    // Two identical tag stores let DMA snooping overlap processor lookups.
    logic [TAG_W-1:0]  cpuTag_reg [ENTRIES];
    logic              cpuTagPar_reg [ENTRIES];
    logic [TAG_W-1:0]  dmaTag_reg [ENTRIES];
    logic              dmaTagPar_reg [ENTRIES];
    logic [ENTRIES-1:0] valid_reg;
    logic [DATA_W-1:0] data_reg [ENTRIES];
    logic              dataPar_reg [ENTRIES];

    wtc_pkg::wtc_state_e state_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              write_reg;
    logic              byte_reg;
    logic              alloc_reg;
    logic              readyPulse_reg;
    logic [INDEX_W-1:0] flushIdx_reg;
    logic [INDEX_W-1:0] invIdx_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Processor lookup.
    logic [INDEX_W-1:0] cIdx;
    logic cacheable, tagMatch, tagPerr, dataPerr, rawHit, hit, perrHit;
    logic doInv, doUpdate, badPar;
    always_comb begin
        cIdx      = idxOf(cpuAddr);
        cacheable = !ioPageSelect && !periphMem
                    && (cpuAddr < wtc_pkg::IO_PAGE_BASE);
        tagMatch  = valid_reg[cIdx] && (cpuTag_reg[cIdx] == tagOf(cpuAddr));
        tagPerr   = valid_reg[cIdx] && (cpuTagPar_reg[cIdx] != ^cpuTag_reg[cIdx]);
        dataPerr  = valid_reg[cIdx] && (dataPar_reg[cIdx] != ^data_reg[cIdx]);
        rawHit    = cacheable && tagMatch;
        perrHit   = 1'b0;
        badPar    = 1'b0;
        if (cpuForceMiss) begin
            hit = 1'b0;
        end else if (cpuBypass) begin
            perrHit = cacheable && (tagPerr || dataPerr);
            hit     = rawHit || perrHit;
        end else if (!cpuWrite) begin
            hit = rawHit && !tagPerr && !dataPerr;
        end else if (cpuByte) begin
            hit    = rawHit || (cacheable && tagPerr);
            badPar = cacheable && tagPerr;
        end else begin
            hit = rawHit;
        end
        doInv    = cpuBypass && !cpuForceMiss && hit;
        doUpdate = cpuWrite && !cpuBypass && !cpuForceMiss && hit;
    end

    // DMA lookup runs every cycle on its own tag store.
    logic [INDEX_W-1:0] dIdx;
    logic dmaHit;
    always_comb begin
        dIdx   = idxOf(dmaAddr);
        dmaHit = dmaValid && dmaWrite && valid_reg[dIdx]
                 && ((dmaTag_reg[dIdx] == tagOf(dmaAddr))
                     || (dmaTagPar_reg[dIdx] != ^dmaTag_reg[dIdx]));
    end

    logic takeCpu;
    assign takeCpu  = (state_reg == wtc_pkg::WTC_IDLE) && cpuReq && !dmaHit && !flushReq;
    assign cpuStall = (state_reg == wtc_pkg::WTC_INV) || (state_reg == wtc_pkg::WTC_FLUSH)
                      || ((state_reg == wtc_pkg::WTC_IDLE) && cpuReq && dmaHit);
    assign cpuReady = readyPulse_reg;
    assign dmaInvalidate = (state_reg == wtc_pkg::WTC_INV);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg      <= wtc_pkg::WTC_IDLE;
            readyPulse_reg <= 1'b0;
            addr_reg       <= '0;
            wdata_reg      <= '0;
            rdata_reg      <= '0;
            write_reg      <= 1'b0;
            byte_reg       <= 1'b0;
            alloc_reg      <= 1'b0;
            flushIdx_reg   <= '0;
            invIdx_reg     <= '0;
        end else begin
            readyPulse_reg <= 1'b0;
            case (state_reg)
                wtc_pkg::WTC_IDLE: begin
                    if (flushReq) begin
                        flushIdx_reg <= '0;
                        state_reg    <= wtc_pkg::WTC_FLUSH;
                    end else if (dmaHit) begin
                        invIdx_reg <= dIdx;
                        state_reg  <= wtc_pkg::WTC_INV;
                    end else if (takeCpu) begin
                        addr_reg  <= cpuAddr;
                        wdata_reg <= cpuWdata;
                        write_reg <= cpuWrite;
                        byte_reg  <= cpuByte;
                        alloc_reg <= !cpuWrite && !cpuBypass && !cpuForceMiss
                                     && cacheable;
                        if (!cpuWrite && hit && !cpuBypass) begin
                            rdata_reg      <= data_reg[cIdx];
                            readyPulse_reg <= 1'b1;
                        end else begin
                            state_reg <= wtc_pkg::WTC_MEM;
                        end
                    end
                end
                wtc_pkg::WTC_MEM: begin
                    if (memAck) begin
                        rdata_reg <= memRdata;
                        state_reg <= wtc_pkg::WTC_DONE;
                    end
                end
                wtc_pkg::WTC_DONE: begin
                    readyPulse_reg <= 1'b1;
                    state_reg      <= wtc_pkg::WTC_IDLE;
                end
                wtc_pkg::WTC_INV: begin
                    state_reg <= wtc_pkg::WTC_IDLE;
                end
                wtc_pkg::WTC_FLUSH: begin
                    flushIdx_reg <= flushIdx_reg + 1'b1;
                    if (flushIdx_reg == INDEX_W'(ENTRIES - 1)) begin
                        state_reg <= wtc_pkg::WTC_IDLE;
                    end
                end
                default: begin
                    state_reg <= wtc_pkg::WTC_IDLE;
                end
            endcase
        end
    end

    assign memReq   = (state_reg == wtc_pkg::WTC_MEM);
    assign memWrite = write_reg;
    assign memByte  = byte_reg;
    assign memAddr  = addr_reg;
    assign memWdata = wdata_reg;
    assign cpuRdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Store updates. Valid bits are shared by both tag stores, so one
    // invalidate covers both copies. A byte write merges into the low or
    // high lane chosen by address bit 0.
    logic [INDEX_W-1:0] fillIdx;
    logic fillNow;
    logic [DATA_W-1:0] merged;
    always_comb begin
        fillIdx = idxOf(addr_reg);
        fillNow = (state_reg == wtc_pkg::WTC_MEM) && memAck && alloc_reg;
        merged  = data_reg[cIdx];
        if (cpuByte && cpuAddr[0]) begin
            merged[DATA_W-1:DATA_W/2] = cpuWdata[DATA_W/2-1:0];
        end else if (cpuByte) begin
            merged[DATA_W/2-1:0] = cpuWdata[DATA_W/2-1:0];
        end else begin
            merged = cpuWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            valid_reg <= {ENTRIES{wtc_pkg::VALID_RST}};
        end else begin
            if (state_reg == wtc_pkg::WTC_FLUSH) begin
                valid_reg[flushIdx_reg] <= 1'b0;
            end else if (state_reg == wtc_pkg::WTC_INV) begin
                valid_reg[invIdx_reg] <= 1'b0;
            end else if (takeCpu && doInv) begin
                valid_reg[cIdx] <= 1'b0;
            end else if (fillNow) begin
                valid_reg[fillIdx] <= 1'b1;
            end
            // A snoop hit while the sequencer is busy would otherwise be lost.
            // It comes last so that it beats a fill of the same entry.
            if (dmaHit) begin
                valid_reg[dIdx] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (fillNow) begin
            cpuTag_reg[fillIdx]    <= tagOf(addr_reg);
            cpuTagPar_reg[fillIdx] <= ^tagOf(addr_reg) ^ wrongTagParity;
            dmaTag_reg[fillIdx]    <= tagOf(addr_reg);
            dmaTagPar_reg[fillIdx] <= ^tagOf(addr_reg) ^ wrongTagParity;
            data_reg[fillIdx]      <= memRdata;
            dataPar_reg[fillIdx]   <= ^memRdata;
        end else if (takeCpu && doUpdate) begin
            data_reg[cIdx]    <= merged;
            dataPar_reg[cIdx] <= ^merged ^ badPar;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_memDone;
        memReq && memAck ##1 (state_reg == wtc_pkg::WTC_DONE) ##1 cpuReady;
    endsequence

    property p_readHitNoMem;
        @(posedge mclk) disable iff (!resetn)
        takeCpu && !cpuWrite && hit && !cpuBypass |=> cpuReady && !memReq;
    endproperty
    a_readHitNoMem: assert property (p_readHitNoMem) else $error("read hit went to memory");

    property p_readMissFill;
        @(posedge mclk) disable iff (!resetn)
        memReq && memAck && alloc_reg && !dmaHit |=> valid_reg[$past(fillIdx)];
    endproperty
    a_readMissFill: assert property (p_readMissFill) else $error("read miss did not fill");

    property p_writeGoesToMem;
        @(posedge mclk) disable iff (!resetn)
        takeCpu && cpuWrite |=> memReq && memWrite;
    endproperty
    a_writeGoesToMem: assert property (p_writeGoesToMem) else $error("write skipped memory");

    property p_writeNoAlloc;
        @(posedge mclk) disable iff (!resetn)
        memReq && memWrite |-> !alloc_reg;
    endproperty
    a_writeNoAlloc: assert property (p_writeNoAlloc) else $error("write allocated");

    property p_ioNoHit;
        @(posedge mclk) disable iff (!resetn)
        takeCpu && (ioPageSelect || periphMem) |=> memReq;
    endproperty
    a_ioNoHit: assert property (p_ioNoHit) else $error("uncached access served from cache");

    property p_dmaInv;
        @(posedge mclk) disable iff (!resetn)
        (state_reg == wtc_pkg::WTC_IDLE) && dmaHit && !flushReq
            |=> dmaInvalidate ##1 !valid_reg[$past(invIdx_reg)];
    endproperty
    a_dmaInv: assert property (p_dmaInv) else $error("dma write hit not invalidated");

    property p_dmaBusyInv;
        @(posedge mclk) disable iff (!resetn)
        (state_reg != wtc_pkg::WTC_IDLE) && dmaHit |=> !valid_reg[$past(dIdx)];
    endproperty
    a_dmaBusyInv: assert property (p_dmaBusyInv) else $error("busy dma hit lost");

    property p_stallOnlyDma;
        @(posedge mclk) disable iff (!resetn)
        (state_reg == wtc_pkg::WTC_IDLE) && cpuReq && !dmaHit |-> !cpuStall;
    endproperty
    a_stallOnlyDma: assert property (p_stallOnlyDma) else $error("needless stall");

    property p_bypassInv;
        @(posedge mclk) disable iff (!resetn)
        takeCpu && doInv |=> !valid_reg[$past(cIdx)] ##0 memReq;
    endproperty
    a_bypassInv: assert property (p_bypassInv) else $error("bypass hit not invalidated");

    property p_memCompletes;
        @(posedge mclk) disable iff (!resetn)
        memReq && memAck |-> s_memDone;
    endproperty
    a_memCompletes: assert property (p_memCompletes) else $error("no ready after memory");
endmodule : wtc_cache
`default_nettype wire

// file: wtc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Main memory behind the cache, answering after ackDelay waiting cycles.
module wtc_mem_model (
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic                       memReq,
    input  wire logic                       memWrite,
    input  wire logic                       memByte,
    input  wire logic [wtc_pkg::ADDR_W-1:0] memAddr,
    input  wire logic [wtc_pkg::DATA_W-1:0] memWdata,
    input  wire logic [3:0]                 ackDelay,
    output logic                            memAck,
    output logic [wtc_pkg::DATA_W-1:0]      memRdata,
    output int                              accessCount
);
    logic [15:0] store [int];
    logic [15:0] word;
    logic [3:0]  waitCnt;
    int          key;

    always @(posedge mclk) begin
        memAck <= 1'b0;
        // Outside an answer the data lines toggle, so stale data is never mistaken for valid.
        memRdata <= ~memRdata;
        if (!resetn) begin
            waitCnt <= 4'h0;
            accessCount <= 0;
            memRdata <= 16'h0000;
        end else if (memReq && !memAck) begin
            if (waitCnt == ackDelay) begin
                key = int'(memAddr[21:1]);
                word = store.exists(key) ? store[key] : (memAddr[16:1] ^ 16'hA5A5);
                if (memWrite && memByte && memAddr[0]) begin
                    word[15:8] = memWdata[7:0];
                end else if (memWrite && memByte) begin
                    word[7:0] = memWdata[7:0];
                end else if (memWrite) begin
                    word = memWdata;
                end
                store[key] = word;
                memRdata <= word;
                memAck <= 1'b1;
                waitCnt <= 4'h0;
                accessCount <= accessCount + 1;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule : wtc_mem_model
`default_nettype wire

// file: wtc_cache_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wtc_cache_tb;
    localparam logic [5:0] RD = 6'h00, WRW = 6'h20, WRB = 6'h30, RDBP = 6'h08;
    localparam logic [5:0] RDFM = 6'h04, RDIO = 6'h02, RDPM = 6'h01;
    localparam logic [21:0] A = 22'h00_1000, B = 22'h00_3000, E = 22'h00_0200, F = 22'h00_2200;
    logic        mclk = 1'b0, resetn = 1'b0, cpuReq = 1'b0, cpuWrite = 1'b0, cpuByte = 1'b0;
    logic        cpuBypass = 1'b0, cpuForceMiss = 1'b0, ioPageSelect = 1'b0, periphMem = 1'b0;
    logic        flushReq = 1'b0, wrongTagParity = 1'b0, dmaValid = 1'b0, dmaWrite = 1'b0;
    logic [21:0] cpuAddr = 22'h00_0000, dmaAddr = 22'h00_0000, memAddr;
    logic [15:0] cpuWdata = 16'h0000, cpuRdata, memWdata, memRdata, rd;
    logic [3:0]  ackDelay = 4'h0;
    logic        cpuReady, cpuStall, memReq, memWrite, memByte, memAck, dmaInvalidate;
    int          accessCount, ops, inv, stall, miscompares = 0, compares = 0;

    always #2.5 mclk = ~mclk;

    wtc_cache wtc_cache_i (.mclk(mclk), .resetn(resetn), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuByte(cpuByte), .cpuBypass(cpuBypass), .cpuForceMiss(cpuForceMiss),
        .ioPageSelect(ioPageSelect), .periphMem(periphMem), .cpuAddr(cpuAddr),
        .cpuWdata(cpuWdata), .cpuReady(cpuReady), .cpuRdata(cpuRdata), .cpuStall(cpuStall),
        .flushReq(flushReq), .wrongTagParity(wrongTagParity), .memReq(memReq),
        .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata), .dmaValid(dmaValid), .dmaWrite(dmaWrite),
        .dmaAddr(dmaAddr), .dmaInvalidate(dmaInvalidate));
    wtc_mem_model wtc_mem_model_i (.mclk(mclk), .resetn(resetn), .memReq(memReq),
        .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
        .ackDelay(ackDelay), .memAck(memAck), .memRdata(memRdata), .accessCount(accessCount));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    // One processor access; reports read data and how many memory cycles it caused.
    task automatic cpu_op(input logic [5:0] kind, input logic [21:0] a, input logic [15:0] wd);
        int n0;
        int t;
        t = 0;
        @(posedge mclk);
        n0 = accessCount;
        {cpuWrite, cpuByte, cpuBypass, cpuForceMiss, ioPageSelect, periphMem} <= kind;
        cpuAddr <= a;
        cpuWdata <= wd;
        cpuReq <= 1'b1;
        do begin
            @(posedge mclk);
            #1;
            t++;
        end while (cpuReady !== 1'b1 && t < 200);
        cpuReq <= 1'b0;
        rd = cpuRdata;
        ops = accessCount - n0;
        if (cpuReady !== 1'b1) begin
            check(1'b0, "processor access never completed");
            give_verdict();
        end
    endtask : cpu_op

    // A one-cycle snoop; the invalidate pulse and the stall land in the following cycles.
    task automatic dma_snoop(input logic wr, input logic [21:0] a);
        @(posedge mclk);
        dmaValid <= 1'b1;
        dmaWrite <= wr;
        dmaAddr <= a;
        @(posedge mclk);
        dmaValid <= 1'b0;
        inv = 0;
        stall = 0;
        repeat (4) begin
            #1;
            inv += int'(dmaInvalidate === 1'b1);
            stall += int'(cpuStall === 1'b1);
            @(posedge mclk);
        end
    endtask : dma_snoop

    // The bypass read empties the entry first, so the next read really fills it.
    task automatic bad_fill_e();
        cpu_op(RDBP, E, 16'h0000);
        wrongTagParity <= 1'b1;
        cpu_op(RD, E, 16'h0000);
        wrongTagParity <= 1'b0;
    endtask : bad_fill_e

    // One flush pulse; the stall lasts one cycle per entry.
    task automatic flush_all();
        int t;
        t = 0;
        @(posedge mclk);
        flushReq <= 1'b1;
        @(posedge mclk);
        flushReq <= 1'b0;
        #1;
        while (cpuStall === 1'b1 && t < 5000) begin
            t++;
            @(posedge mclk);
            #1;
        end
        check(t == wtc_pkg::ENTRIES, "flush length");
        if (t == 5000) begin
            give_verdict();
        end
    endtask : flush_all

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        cpu_op(RD, A, 16'h0000);
        check(rd === (A[16:1] ^ 16'hA5A5) && ops == 1, "read miss");
        cpu_op(RD, A, 16'h0000);
        check(rd === (A[16:1] ^ 16'hA5A5) && ops == 0, "read hit");
        ackDelay <= 4'h3;
        cpu_op(WRW, A, 16'h1234);
        check(ops == 1, "write hit memory");
        cpu_op(RD, A, 16'h0000);
        check(rd === 16'h1234 && ops == 0, "write hit cache");
        cpu_op(WRW, B, 16'hBEEF);
        cpu_op(RD, A, 16'h0000);
        check(rd === 16'h1234 && ops == 0, "write miss changed cache");
        cpu_op(RD, B, 16'h0000);
        check(rd === 16'hBEEF && ops == 1, "write miss memory");
        cpu_op(RD, A, 16'h0000);
        check(rd === 16'h1234 && ops == 1, "same index evicts");
        cpu_op(WRB, A | 22'h00_0001, 16'h005A);
        cpu_op(RD, A, 16'h0000);
        check(rd === 16'h5A34 && ops == 0, "byte write hit");
        repeat (2) begin
            cpu_op(RDIO, 22'h3F_E010, 16'h0000);
            check(ops == 1, "io page cached");
            cpu_op(RDPM, 22'h01_0040, 16'h0000);
            check(ops == 1, "peripheral memory cached");
        end
        cpu_op(RDFM, A, 16'h0000);
        check(rd === 16'h5A34 && ops == 1, "force miss read");
        cpu_op(RD, A, 16'h0000);
        check(ops == 0, "force miss changed cache");
        dma_snoop(1'b0, A);
        check(inv == 0 && stall == 0, "dma read stalled");
        dma_snoop(1'b1, B);
        check(inv == 0 && stall == 0, "dma write miss invalidated");
        dma_snoop(1'b1, A);
        check(inv == 1 && stall == 1, "dma write hit");
        cpu_op(RD, A, 16'h0000);
        check(ops == 1, "entry survived dma write");
        cpu_op(RDBP, A, 16'h0000);
        check(ops == 1, "bypass read hit");
        cpu_op(RD, A, 16'h0000);
        check(ops == 1, "bypass hit not invalidated");
        fork
            cpu_op(RDFM, A, 16'h0000);
            begin
                repeat (3) @(posedge mclk);
                dma_snoop(1'b1, A);
            end
        join
        cpu_op(RD, A, 16'h0000);
        check(ops == 1, "dma write hit during memory cycle lost");
        bad_fill_e();
        cpu_op(RD, E, 16'h0000);
        check(rd === (E[16:1] ^ 16'hA5A5) && ops == 1, "parity read not miss");
        cpu_op(RD, E, 16'h0000);
        check(ops == 0, "refill not cached");
        bad_fill_e();
        dma_snoop(1'b1, F);
        check(inv == 1, "dma tag parity not hit");
        bad_fill_e();
        cpu_op(RDBP, E, 16'h0000);
        check(rd === (E[16:1] ^ 16'hA5A5) && ops == 1, "bypass parity");
        dma_snoop(1'b1, F);
        check(inv == 0, "bypass parity entry kept");
        bad_fill_e();
        cpu_op(WRB, E, 16'h7777);
        cpu_op(RD, E, 16'h0000);
        check(rd === {E[16:9] ^ 8'hA5, 8'h77} && ops == 1, "byte write parity");
        flush_all();
        cpu_op(RD, A, 16'h0000);
        check(ops == 1, "flush left entry valid");
        give_verdict();
    end
endmodule : wtc_cache_tb
`default_nettype wire
